// ===== design/dpr_pkg.sv
/*
  package for the dual-port ram port control: widths, counter modes,
  packed control bundle and reset values.
  assumes one clock per port and an active-low asynchronous reset.
*/
package dpr_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam int LANE_W = 9;
  localparam int DATA_W = 2 * LANE_W;
  localparam int NUM_LANES = 2;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 15'h0000;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 15'h0001;
  localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
  localparam int READ_LATENCY = 1;

  // ----------------------------------------------------------------
  // counter modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DPR_CNT_HOLD  = 2'h0,
    DPR_CNT_STEP  = 2'h1,
    DPR_CNT_LOAD  = 2'h3,
    DPR_CNT_CLEAR = 2'h2
  } dpr_cnt_mode_t;

  // sampled synchronous controls of one port
  typedef struct packed {
    logic                 select_low_n;
    logic                 select_high;
    logic                 write_n;
    logic [NUM_LANES-1:0] lane_enables_n;
    logic                 address_load_n;
    logic                 count_advance_n;
    logic                 count_clear_n;
  } dpr_ctrl_t;

  localparam dpr_ctrl_t CTRL_RST = '{1'h1, 1'h0, 1'h1, 2'h3, 1'h1, 1'h1, 1'h1};

endpackage

// ===== design/dpr_addr_counter.sv
/*
  burst address counter of one port: clear, load, hold or step.
  assumes inputs are already registered on the port clock.
*/
`timescale 1ns/1ns
module dpr_addr_counter
  import dpr_pkg::*;
#(
  parameter int AW = ADDR_W
) (
  input  wire logic          i_clk,
  input  wire logic          i_reset_n,
  input  wire logic          i_address_load_n,
  input  wire logic          i_count_advance_n,
  input  wire logic          i_count_clear_n,
  input  wire logic [AW-1:0] i_addr,
  output logic      [AW-1:0] o_addr_used
);

  logic [AW-1:0] held_r;
  logic [AW-1:0] held_nxt;
  dpr_cnt_mode_t mode;

  // ----------------------------------------------------------------
  // mode priority: clear over load over count
  // ----------------------------------------------------------------
  always_comb begin
    if (!i_count_clear_n) begin
      mode = DPR_CNT_CLEAR;
    end else if (!i_address_load_n) begin
      mode = DPR_CNT_LOAD;
    end else if (!i_count_advance_n) begin
      mode = DPR_CNT_STEP;
    end else begin
      mode = DPR_CNT_HOLD;
    end
  end

  always_comb begin
    case (mode)
      DPR_CNT_CLEAR: held_nxt = AW'(ADDR_ZERO);
      DPR_CNT_LOAD:  held_nxt = i_addr;
      DPR_CNT_STEP:  held_nxt = held_r + AW'(ADDR_STEP);
      DPR_CNT_HOLD:  held_nxt = held_r;
      default:       held_nxt = held_r;
    endcase
  end

  // address in use this access is the updated counter value
  assign o_addr_used = held_nxt;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      held_r <= AW'(ADDR_ZERO);
    end else begin
      held_r <= held_nxt;
    end
  end

endmodule

// ===== design/dpr_port_ctrl.sv
/*
  one port of a pipelined dual-port static ram: registered inputs, lane
  enables, write path, one-cycle read pipe, asynchronous output enable.
  the word array is passed in from a shared store: this module drives the
  write request and takes the read word combinationally from its address.
  assumes all synchronous inputs come from logic on I_SYS_CLK; the output
  enable pin is asynchronous and is applied outside the register stage.
*/
`timescale 1ns/1ns
module dpr_port_ctrl
  import dpr_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int LW = LANE_W
) (
  input  wire logic              I_SYS_CLK,
  input  wire logic              I_RESET_N,
  input  wire logic              I_SELECT_LOW_N,
  input  wire logic              I_SELECT_HIGH,
  input  wire logic              I_WRITE_N,
  input  wire logic              I_UPPER_LANE_ENABLE_N,
  input  wire logic              I_LOWER_LANE_ENABLE_N,
  input  wire logic              I_OUTPUT_ENABLE_N,
  input  wire logic              I_ADDRESS_LOAD_N,
  input  wire logic              I_COUNT_ADVANCE_N,
  input  wire logic              I_COUNT_CLEAR_N,
  input  wire logic [AW-1:0]     I_ADDR,
  input  wire logic [2*LW-1:0]   I_DATA,
  input  wire logic [2*LW-1:0]   I_MEM_RDATA,
  output logic      [AW-1:0]     O_MEM_ADDR,
  output logic      [1:0]        O_MEM_WE,
  output logic      [2*LW-1:0]   O_MEM_WDATA,
  output logic      [2*LW-1:0]   O_DATA,
  output logic      [1:0]        O_DATA_OE_N
);

  // ----------------------------------------------------------------
  // input registers
  // ----------------------------------------------------------------
  dpr_ctrl_t       ctrl_r;
  logic [AW-1:0]   addr_r;
  logic [2*LW-1:0] data_r;
  logic [AW-1:0]   addr_used;
  logic            sel;
  logic [1:0]      lane_on;

  // every control except output enable is sampled on this port's own clock only
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ctrl_r <= CTRL_RST;
      addr_r <= AW'(ADDR_ZERO);
      data_r <= (2*LW)'(DATA_RST);
    end else begin
      ctrl_r <= '{I_SELECT_LOW_N, I_SELECT_HIGH, I_WRITE_N,
                  {I_UPPER_LANE_ENABLE_N, I_LOWER_LANE_ENABLE_N},
                  I_ADDRESS_LOAD_N, I_COUNT_ADVANCE_N, I_COUNT_CLEAR_N};
      addr_r <= I_ADDR;
      data_r <= I_DATA;
    end
  end

  // ----------------------------------------------------------------
  // address counter, independent of selects
  // ----------------------------------------------------------------
  dpr_addr_counter #(
    .AW (AW)
  ) u_cnt (
    .i_clk             (I_SYS_CLK),
    .i_reset_n         (I_RESET_N),
    .i_address_load_n  (ctrl_r.address_load_n),
    .i_count_advance_n (ctrl_r.count_advance_n),
    .i_count_clear_n   (ctrl_r.count_clear_n),
    .i_addr            (addr_r),
    .o_addr_used       (addr_used)
  );

  assign sel = !ctrl_r.select_low_n && ctrl_r.select_high;
  assign O_MEM_ADDR = addr_used;

  // ----------------------------------------------------------------
  // per-lane write and read-drive enables
  // ----------------------------------------------------------------
  logic [1:0]      rd_lane_r;
  logic [2*LW-1:0] rdata_r;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_lane
      // lane 0 is bits 8:0, lane 1 is bits 17:9
      assign lane_on[g] = sel && !ctrl_r.lane_enables_n[g];
      // writes never look at output enable
      assign O_MEM_WE[g] = lane_on[g] && !ctrl_r.write_n;
      assign O_MEM_WDATA[g*LW +: LW] = data_r[g*LW +: LW];

      always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
          rd_lane_r[g] <= 1'h0;
        end else begin
          rd_lane_r[g] <= lane_on[g] && ctrl_r.write_n;
        end
      end

      // output enable gates the pipeline stage with no clock involved
      assign O_DATA_OE_N[g] = I_OUTPUT_ENABLE_N || !rd_lane_r[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // read pipeline
  // ----------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rdata_r <= (2*LW)'(DATA_RST);
    end else begin
      rdata_r <= I_MEM_RDATA;
    end
  end

  assign O_DATA = rdata_r;

endmodule

// ===== testbench/dpr_monitor.sv
/*
  checker for one ram port: counter modes, lane strobes, read pipe, output enable.
  assumes it is bound onto dpr_port_ctrl, one clock, reset low is asynchronous.
*/
`timescale 1ns/1ns
module dpr_monitor
  import dpr_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int LW = LANE_W
) (
  input wire logic            I_SYS_CLK,
  input wire logic            I_RESET_N,
  input wire logic            I_SELECT_LOW_N,
  input wire logic            I_SELECT_HIGH,
  input wire logic            I_WRITE_N,
  input wire logic            I_UPPER_LANE_ENABLE_N,
  input wire logic            I_LOWER_LANE_ENABLE_N,
  input wire logic            I_OUTPUT_ENABLE_N,
  input wire logic            I_ADDRESS_LOAD_N,
  input wire logic            I_COUNT_ADVANCE_N,
  input wire logic            I_COUNT_CLEAR_N,
  input wire logic [AW-1:0]   I_ADDR,
  input wire logic [2*LW-1:0] I_MEM_RDATA,
  input wire logic [AW-1:0]   O_MEM_ADDR,
  input wire logic [1:0]      O_MEM_WE,
  input wire logic [2*LW-1:0] O_DATA,
  input wire logic [1:0]      O_DATA_OE_N
);
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESET_N);
  wire logic       sel = !I_SELECT_LOW_N && I_SELECT_HIGH;
  wire logic [1:0] ln  = {I_UPPER_LANE_ENABLE_N, I_LOWER_LANE_ENABLE_N};
  a_clear_zero: assert property (!I_COUNT_CLEAR_N |=> O_MEM_ADDR == AW'(ADDR_ZERO))
    else $error("clear missed");
  a_load_ext: assert property (
    I_COUNT_CLEAR_N && !I_ADDRESS_LOAD_N |=> O_MEM_ADDR == $past(I_ADDR))
    else $error("load missed");
  a_hold_addr: assert property (
    I_COUNT_CLEAR_N && I_ADDRESS_LOAD_N && I_COUNT_ADVANCE_N |=> $stable(O_MEM_ADDR))
    else $error("hold moved");
  a_step_addr: assert property (
    I_COUNT_CLEAR_N && I_ADDRESS_LOAD_N && !I_COUNT_ADVANCE_N
    |=> O_MEM_ADDR == AW'($past(O_MEM_ADDR) + AW'(ADDR_STEP))) else $error("step wrong");
  a_write_lanes: assert property (
    sel && !I_WRITE_N |=> O_MEM_WE == ~$past(ln)) else $error("write strobe wrong");
  a_read_drive: assert property (sel && I_WRITE_N
    |-> ##2 (I_OUTPUT_ENABLE_N || O_DATA_OE_N == $past(ln, 2))) else $error("drive wrong");
  a_oe_float: assert property (I_OUTPUT_ENABLE_N |-> O_DATA_OE_N == 2'h3)
    else $error("driving while disabled");
  a_read_data: assert property (sel && I_WRITE_N && ln == 2'h0
    |-> ##2 O_DATA == $past(I_MEM_RDATA)) else $error("read data wrong");
endmodule

// ===== testbench/dpr_mem_model.sv
/*
  word store behind one port; old word is read while it is being written.
  assumes write strobes come from the port on the same clock.
*/
`timescale 1ns/1ns
module dpr_mem_model
  import dpr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [1:0]        we,
  input  wire logic [DATA_W-1:0] wdata,
  output logic      [DATA_W-1:0] rdata
);
  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [DATA_W-1:0] arr [2**ADDR_W];
  assign rdata = arr[addr];
  always @(posedge clk) begin
    if (we[0]) arr[addr][8:0] <= wdata[8:0];
    if (we[1]) arr[addr][17:9] <= wdata[17:9];
  end
endmodule

// ===== testbench/test_dual_port_ram_port_control.sv
/*
  bench for one ram port: directed corners, then seeded random traffic.
  assumes the store model and the checker beside it; no waits beyond fixed latency.
*/
`timescale 1ns/1ns
module test_dual_port_ram_port_control
  import dpr_pkg::*;
;
  // ------------------------------------------------------------
  // stimulus and expectation
  // ------------------------------------------------------------
  logic        clk = 1'h0, rst_n = 1'h0, rd = 1'h0, sel;
  logic [8:0]  cv = 9'h177, pc = 9'h177;
  logic [14:0] av = 15'h0000, pa = 15'h0000, cnt = 15'h0000, ma;
  logic [17:0] dv = 18'h00000, pd = 18'h00000, re, m, wd, rdat, dout;
  logic [1:0]  we, oe_n, rl = 2'h3;
  logic [31:0] x = 32'h2;
  logic [17:0] em [2**ADDR_W];
  int          err_count = 0, checked = 0;
  initial forever #50 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // clear beats load beats advance
  function automatic logic [14:0] nxt(input logic [8:0] c, input logic [14:0] a, p);
    if (!c[0]) return 15'h0000;
    if (!c[2]) return a;
    return c[1] ? p : p + 15'h1;
  endfunction
  task automatic chk(input string n, input logic [17:0] s, e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic conclude();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // checks at the falling edge, so every output has settled
  task automatic step(input logic [8:0] c, input logic [14:0] a, input logic [17:0] d);
    @(posedge clk);
    {cv, av, dv} <= {c, a, d};
    @(negedge clk);
    cnt = nxt(pc, pa, cnt);
    m = {{9{~rl[1]}}, {9{~rl[0]}}};
    chk("addr", 18'(ma), 18'(cnt));
    chk("oe", {16'h0, oe_n}, c[3] ? 18'h3 : rd ? {16'h0, rl} : 18'h3);
    if (rd) chk("rdata", dout & m, re & m);
    sel = !pc[8] && pc[7];
    chk("we", {16'h0, we}, (sel && !pc[6]) ? {16'h0, ~pc[5:4]} : 18'h0);
    {rd, rl, re} = {sel && pc[6], pc[5:4], em[cnt]};
    if (sel && !pc[6] && !pc[4]) em[cnt][8:0] = pd[8:0];
    if (sel && !pc[6] && !pc[5]) em[cnt][17:9] = pd[17:9];
    {pc, pa, pd} = {c, a, d};
  endtask
  initial begin
    for (int i = 0; i < 2**ADDR_W; i++) begin
      em[i] = {3'h5, 15'(i)};
      u_mem.arr[i] = em[i];
    end
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    step(9'h083, 15'h7fff, 18'h2a5a5);
    step(9'h0a5, 15'h1234, 18'h1c3c3);
    step(9'h0ca, 15'h7fff, 18'h00000);
    step(9'h0cf, 15'h0000, 18'h00000);
    step(9'h0c7, 15'h0000, 18'h00000);
    repeat (3000) begin
      x = xs(x);
      step({x[8] & x[20], x[7] | x[21], x[6:4], x[3] & x[23], x[2:1], x[0] | x[22]},
           {{12{x[24]}}, x[27:25]}, x[31:14]);
    end
    conclude();
  end
  dpr_port_ctrl DUT (.I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_SELECT_LOW_N(cv[8]),
    .I_SELECT_HIGH(cv[7]), .I_WRITE_N(cv[6]), .I_UPPER_LANE_ENABLE_N(cv[5]),
    .I_LOWER_LANE_ENABLE_N(cv[4]), .I_OUTPUT_ENABLE_N(cv[3]), .I_ADDRESS_LOAD_N(cv[2]),
    .I_COUNT_ADVANCE_N(cv[1]), .I_COUNT_CLEAR_N(cv[0]), .I_ADDR(av), .I_DATA(dv),
    .I_MEM_RDATA(rdat), .O_MEM_ADDR(ma), .O_MEM_WE(we), .O_MEM_WDATA(wd), .O_DATA(dout),
    .O_DATA_OE_N(oe_n));
  dpr_mem_model u_mem (.clk(clk), .addr(ma), .we(we), .wdata(wd), .rdata(rdat));
endmodule
bind dpr_port_ctrl dpr_monitor #(.AW(AW), .LW(LW)) u_mon (.*);
